// File: iexp_top.sv
// interrupt expander with vector store and three external edge channels
`timescale 1ns/1ps
module iexp_top
  import iexp_pkg::*;
#(
  parameter logic [N_SRC-1:0] SRC_USED = {{(N_SRC-N_USED){1'b0}},
                                          {N_USED{1'b1}}},
  parameter int GPIO_W = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // peripheral sources and first gpio port
  input wire logic [N_SRC-1:0] periph_irq,
  input wire logic [GPIO_W-1:0] gpio_port_a,
  // processor side
  input wire iexp_ack_t cpu_ack,
  output iexp_vec_t cpu_vec,
  output logic [N_GROUPS-1:0] cpu_irq_lines,
  output logic cpu_irq_line_thirteen,
  output logic cpu_nmi,
  output logic ext_irq_first,
  output logic ext_irq_second,
  output logic irq
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (GPIO_W < 1 || GPIO_W > (1 << PIN_W)) begin : g_bad_gpio
    $error("GPIO_W out of range");
  end

  function automatic logic [2:0] first_set8(input logic [7:0] v);
    first_set8 = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set8 = 3'(i);
      end
    end
  endfunction

  function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
    is_ofs = (a[11:2] == o[11:2]);
  endfunction

  // ****************************************************************
  // bus slave: address phase capture
  // ****************************************************************
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic ctrl_en_ff;
  logic [N_SRC-1:0] src_en_ff;
  logic [N_SRC-1:0] pend_ff;
  iexp_xcfg_t xcfg_ff [N_EXT];
  logic [CNT_W-1:0] xcnt_ff [N_EXT];
  logic [N_EXT-1:0] istat_ff;
  logic [N_EXT-1:0] imask_ff;
  logic [VEC_W-1:0] vec_ram [N_SRC];
  logic [31:0] nxt_rdata;
  logic acc;

  assign acc = hsel && hready && htrans[1];

  always_comb begin
    logic [11:0] a;
    a = haddr[11:0];
    nxt_rdata = 32'h0000_0000;
    if (a >= OFS_VEC0 && a < OFS_VEC_END) begin
      nxt_rdata = vec_ram[7'(a[11:2] - OFS_VEC0[11:2])];
    end else if (is_ofs(a, OFS_CTRL)) begin
      nxt_rdata[CTRL_EN_BIT] = ctrl_en_ff;
    end else if (is_ofs(a, OFS_ISTAT)) begin
      nxt_rdata[N_EXT-1:0] = istat_ff;
    end else if (is_ofs(a, OFS_IMASK)) begin
      nxt_rdata[N_EXT-1:0] = imask_ff;
    end else begin
      for (int k = 0; k < N_SRC / 32; k++) begin
        if (is_ofs(a, OFS_EN0 + 12'(4 * k))) begin
          nxt_rdata = src_en_ff[32*k +: 32];
        end
        if (is_ofs(a, OFS_PEND0 + 12'(4 * k))) begin
          nxt_rdata = pend_ff[32*k +: 32];
        end
      end
      for (int c = 0; c < N_EXT; c++) begin
        if (is_ofs(a, OFS_XCFG0 + 12'(4 * c))) begin
          nxt_rdata[XCFG_EDGE_LSB +: 2] = xcfg_ff[c].edge_sel;
          nxt_rdata[XCFG_EN_BIT] = xcfg_ff[c].en;
          nxt_rdata[XCFG_PIN_LSB +: PIN_W] = xcfg_ff[c].pin;
          nxt_rdata[XCFG_NMI_BIT] = xcfg_ff[c].nmi_route;
        end
        if (is_ofs(a, OFS_XCNT0 + 12'(4 * c))) begin
          nxt_rdata[CNT_W-1:0] = xcnt_ff[c];
        end
      end
    end
  end

  // read data is registered in the address phase so hrdata is a flop;
  // the master's idle cycle between transfers keeps it coherent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc) begin
        wr_addr_ff <= haddr[11:0];
      end
      if (acc && !hwrite) begin
        hrdata_ff <= nxt_rdata;
      end
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_ff <= CTRL_RST;
      src_en_ff <= SRC_EN_RST;
      imask_ff <= '0;
      for (int c = 0; c < N_EXT; c++) begin
        xcfg_ff[c] <= XCFG_RST;
      end
    end else if (wr_pend_ff) begin
      if (is_ofs(wr_addr_ff, OFS_CTRL)) begin
        ctrl_en_ff <= hwdata[CTRL_EN_BIT];
      end
      if (is_ofs(wr_addr_ff, OFS_IMASK)) begin
        imask_ff <= hwdata[N_EXT-1:0];
      end
      for (int k = 0; k < N_SRC / 32; k++) begin
        if (is_ofs(wr_addr_ff, OFS_EN0 + 12'(4 * k))) begin
          src_en_ff[32*k +: 32] <= hwdata;
        end
      end
      for (int c = 0; c < N_EXT; c++) begin
        if (is_ofs(wr_addr_ff, OFS_XCFG0 + 12'(4 * c))) begin
          xcfg_ff[c].edge_sel <= hwdata[XCFG_EDGE_LSB +: 2];
          xcfg_ff[c].en <= hwdata[XCFG_EN_BIT];
          xcfg_ff[c].pin <= hwdata[XCFG_PIN_LSB +: PIN_W];
          xcfg_ff[c].nmi_route <= hwdata[XCFG_NMI_BIT];
        end
      end
    end
  end

  // vector store has no reset: software fills it before enabling sources
  always_ff @(posedge hclk) begin
    if (wr_pend_ff && wr_addr_ff >= OFS_VEC0 && wr_addr_ff < OFS_VEC_END) begin
      vec_ram[7'(wr_addr_ff[11:2] - OFS_VEC0[11:2])] <= hwdata;
    end
  end

  // ****************************************************************
  // expander: pending, selection, vector hand-off
  // ****************************************************************
  logic [N_SRC-1:0] src_live;
  logic [N_SRC-1:0] clr_vec;
  logic [N_GROUPS-1:0] grp_req;
  logic [2:0] sel_pos;
  logic [SRC_IDX_W-1:0] sel_src;
  logic sel_any;
  logic [LINE_W-1:0] ack_line;
  iexp_vec_t vec_ff;
  logic [N_GROUPS-1:0] lines_ff;

  assign src_live = periph_irq & SRC_USED;
  assign ack_line = (cpu_ack.line < LINE_W'(N_GROUPS)) ? cpu_ack.line
                                                        : LINE_W'(0);

  always_comb begin
    logic [7:0] g;
    g = pend_ff[ack_line*GRP_SIZE +: GRP_SIZE]
        & src_en_ff[ack_line*GRP_SIZE +: GRP_SIZE];
    sel_any = |g;
    sel_pos = first_set8(g);
    sel_src = SRC_IDX_W'(ack_line * GRP_SIZE) + SRC_IDX_W'(sel_pos);
    clr_vec = '0;
    if (cpu_ack.valid && sel_any) begin
      clr_vec[sel_src] = 1'b1;
    end
    for (int i = 0; i < N_GROUPS; i++) begin
      grp_req[i] = ctrl_en_ff
                   && |(pend_ff[i*GRP_SIZE +: GRP_SIZE]
                        & src_en_ff[i*GRP_SIZE +: GRP_SIZE]);
    end
  end

  // a source still asserting in the service cycle keeps its pending bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~clr_vec) | src_live;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_ff <= '0;
      lines_ff <= '0;
    end else begin
      lines_ff <= grp_req;
      vec_ff.valid <= cpu_ack.valid;
      vec_ff.spurious <= cpu_ack.valid && !sel_any;
      if (cpu_ack.valid) begin
        vec_ff.src <= sel_src;
        vec_ff.vec <= sel_any ? vec_ram[sel_src] : VEC_RST;
      end
    end
  end

  assign cpu_vec = vec_ff;
  assign cpu_irq_lines = lines_ff;

  // ****************************************************************
  // external channels
  // ****************************************************************
  logic [N_EXT-1:0] pin_now;
  logic [N_EXT-1:0] pin_prev_ff;
  logic [N_EXT-1:0] edge_hit;
  logic [N_EXT-1:0] w1c;
  logic [1:0] outs_ff;
  logic irq_ff;

  always_comb begin
    for (int c = 0; c < N_EXT; c++) begin
      // compared at 32 bits: a full 32-pin port does not fit a 5-bit bound
      pin_now[c] = (32'(xcfg_ff[c].pin) < GPIO_W) ?
                   gpio_port_a[xcfg_ff[c].pin] : 1'b0;
      edge_hit[c] = xcfg_ff[c].en && (
        (xcfg_ff[c].edge_sel[1] && pin_now[c] && !pin_prev_ff[c]) ||
        (xcfg_ff[c].edge_sel[0] && !pin_now[c] && pin_prev_ff[c]));
    end
    w1c = (wr_pend_ff && is_ofs(wr_addr_ff, OFS_ISTAT)) ?
          hwdata[N_EXT-1:0] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_ff <= '0;
      for (int c = 0; c < N_EXT; c++) begin
        xcnt_ff[c] <= '0;
      end
    end else begin
      pin_prev_ff <= pin_now;
      for (int c = 0; c < N_EXT; c++) begin
        xcnt_ff[c] <= edge_hit[c] ? '0 : xcnt_ff[c] + 1'b1;
      end
    end
  end

  // edge wins over a write-one-clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_ff <= '0;
    end else begin
      istat_ff <= (istat_ff & ~w1c) | edge_hit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outs_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      outs_ff[0] <= istat_ff[0] && imask_ff[0];
      outs_ff[1] <= istat_ff[1] && imask_ff[1];
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // third channel: route bit picks line thirteen or nmi
  logic x13_ff;
  logic nmi_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x13_ff <= 1'b0;
      nmi_ff <= 1'b0;
    end else begin
      x13_ff <= istat_ff[2] && imask_ff[2] && !xcfg_ff[2].nmi_route;
      nmi_ff <= istat_ff[2] && imask_ff[2] && xcfg_ff[2].nmi_route;
    end
  end

  assign ext_irq_first = outs_ff[0];
  assign ext_irq_second = outs_ff[1];
  assign cpu_irq_line_thirteen = x13_ff;
  assign cpu_nmi = nmi_ff;
  assign irq = irq_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ack;
    cpu_ack.valid;
  endsequence
  sequence s_vec;
    cpu_vec.valid;
  endsequence

  AST_VEC_LAT: assert property (s_ack |-> ##1 s_vec)
    else $error("vector not answered in one cycle");
  AST_VEC_WITHIN: assert property (s_ack |-> ##[1:8] s_vec)
    else $error("vector missing within eight cycles");
  AST_UNUSED_SRC: assert property ((pend_ff & ~SRC_USED) == '0)
    else $error("unwired source became pending");
  AST_DIS_LINE: assert property (
    (src_en_ff[7:0] == 8'h00) |=> !cpu_irq_lines[0])
    else $error("disabled group drove its line");
  AST_LOWEST: assert property (
    (cpu_ack.valid && sel_any) |=>
      (cpu_vec.src[2:0] == first_set8(
        $past(pend_ff[ack_line*GRP_SIZE +: GRP_SIZE]
              & src_en_ff[ack_line*GRP_SIZE +: GRP_SIZE]))))
    else $error("not lowest pending source");
  AST_CNT_CLR: assert property (edge_hit[0] |=> xcnt_ff[0] == '0)
    else $error("timestamp not cleared on edge");
  AST_CNT_RUN: assert property (
    (hresetn && !edge_hit[1])
      |=> xcnt_ff[1] == $past(xcnt_ff[1]) + 16'h0001)
    else $error("timestamp not counting");
  AST_CH_EN: assert property (!xcfg_ff[2].en |-> !edge_hit[2])
    else $error("disabled channel fired");
  AST_RISE_ONLY: assert property (
    (xcfg_ff[0].edge_sel == EDGE_RISE && edge_hit[0]) |-> pin_now[0])
    else $error("rising-only fired on fall");
  AST_NMI_ROUTE: assert property (cpu_nmi |-> !cpu_irq_line_thirteen)
    else $error("third channel on both outputs");
  AST_GRP_LINE: assert property (
    (ctrl_en_ff && |(pend_ff[15:8] & src_en_ff[15:8]))
      |=> cpu_irq_lines[1])
    else $error("group two line missing");

endmodule

// File: iexp_pkg.sv
// shared constants and carrier types of the interrupt expander block
package iexp_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int N_GROUPS = 12;
  localparam int GRP_SIZE = 8;
  localparam int N_SRC = 96;
  localparam int N_USED = 43;
  localparam int N_EXT = 3;
  localparam int CNT_W = 16;
  localparam int VEC_W = 32;
  localparam int SRC_IDX_W = 7;
  localparam int LINE_W = 4;
  localparam int PIN_W = 5;
  // longest allowed ack-to-vector latency, in processor cycles
  localparam int VEC_LAT_MAX = 8;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_EN0 = 12'h010;
  localparam logic [11:0] OFS_PEND0 = 12'h020;
  localparam logic [11:0] OFS_XCFG0 = 12'h030;
  localparam logic [11:0] OFS_XCNT0 = 12'h040;
  localparam logic [11:0] OFS_ISTAT = 12'h050;
  localparam logic [11:0] OFS_IMASK = 12'h054;
  localparam logic [11:0] OFS_VEC0 = 12'h400;
  localparam logic [11:0] OFS_VEC_END = 12'h580;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int XCFG_EDGE_LSB = 0;
  localparam int XCFG_EN_BIT = 2;
  localparam int XCFG_PIN_LSB = 4;
  localparam int XCFG_NMI_BIT = 12;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [VEC_W-1:0] VEC_RST = 32'h0000_0000;
  localparam logic [N_SRC-1:0] SRC_EN_RST = '0;

  // edge selection codes
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic nmi_route;
    logic [PIN_W-1:0] pin;
    logic en;
    logic [1:0] edge_sel;
  } iexp_xcfg_t;

  localparam iexp_xcfg_t XCFG_RST = '0;

  typedef struct packed {
    logic valid;
    logic [LINE_W-1:0] line;
  } iexp_ack_t;

  typedef struct packed {
    logic valid;
    logic spurious;
    logic [SRC_IDX_W-1:0] src;
    logic [VEC_W-1:0] vec;
  } iexp_vec_t;

endpackage

// File: iexp_cpu_model.sv
// processor model that services the expander lines and times the vector
`timescale 1ns/1ps
module iexp_cpu_model
  import iexp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // service control from the bench
  input wire logic svc_en,
  input wire logic [3:0] svc_wait,
  // expander side
  input wire logic [N_GROUPS-1:0] cpu_irq_lines,
  input wire iexp_vec_t cpu_vec,
  output iexp_ack_t cpu_ack,
  output int late_cnt
);
  logic [SRC_IDX_W-1:0] srcs[$];
  logic [VEC_W-1:0] vecs[$];
  int k;
  logic [LINE_W-1:0] pick;
  initial begin
    cpu_ack = '0;
    late_cnt = 0;
    forever begin
      @(posedge hclk);
      if (hresetn && svc_en && |cpu_irq_lines) begin
        repeat (svc_wait) @(posedge hclk);
        // lowest line wins, a fixed order
        pick = '0;
        for (k = N_GROUPS - 1; k >= 0; k--) begin
          if (cpu_irq_lines[k]) begin
            pick = k[LINE_W-1:0];
          end
        end
        cpu_ack.line <= pick;
        cpu_ack.valid <= 1'b1;
        @(posedge hclk);
        cpu_ack.valid <= 1'b0;
        k = 0;
        do begin
          @(posedge hclk);
          k++;
        end while (cpu_vec.valid !== 1'b1 && k < VEC_LAT_MAX);
        if (cpu_vec.valid !== 1'b1) begin
          late_cnt++;
        end
        srcs.push_back(cpu_vec.src);
        vecs.push_back(cpu_vec.vec);
        // give the line time to fall before looking again
        repeat (2) @(posedge hclk);
      end
    end
  end
endmodule

// File: tb_iexp_top.sv
// self-checking bench for the interrupt expander and external channels
`timescale 1ns/1ps
module tb_iexp_top;
  import iexp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [N_SRC-1:0] periph_irq = '0;
  logic [31:0] gpio_port_a = '0;
  logic svc_en = 1'b0;
  logic [3:0] svc_wait = 4'h3;
  iexp_ack_t cpu_ack;
  iexp_vec_t cpu_vec;
  logic [N_GROUPS-1:0] lines;
  logic l13, nmi, x1, x2, irq;
  int late_cnt;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int i, c0, c1, c2;
  logic [31:0] r, v0;

  always #2 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  iexp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .periph_irq(periph_irq), .gpio_port_a(gpio_port_a),
    .cpu_ack(cpu_ack), .cpu_vec(cpu_vec), .cpu_irq_lines(lines),
    .cpu_irq_line_thirteen(l13), .cpu_nmi(nmi), .ext_irq_first(x1),
    .ext_irq_second(x2), .irq(irq));

  iexp_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .svc_en(svc_en),
    .svc_wait(svc_wait), .cpu_irq_lines(lines), .cpu_vec(cpu_vec),
    .cpu_ack(cpu_ack), .late_cnt(late_cnt));

  task automatic chk(input string w, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask

  // one single transfer; c is the cycle of the address edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rv,
                     output int c);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    c = cyc;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    int c;
    bus(1'b1, a, d, x, c);
  endtask

  task automatic rc(input string w, input logic [11:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    int c;
    bus(1'b0, a, 32'h0, x, c);
    chk(w, x, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("ctrl", OFS_CTRL, 32'h0);
    rc("en0", OFS_EN0, 32'h0);
    rc("unmapped", 12'h300, 32'h0);
    for (i = 0; i < N_SRC; i++) begin
      wr(OFS_VEC0 + 12'(4 * i), 32'hBE00_0000 | 32'(i));
    end
    for (i = 0; i < N_SRC; i++) begin
      rc("vec", OFS_VEC0 + 12'(4 * i), 32'hBE00_0000 | 32'(i));
    end
    // sources 0,1,9 and wired-off 50 enabled, source 2 left disabled
    wr(OFS_CTRL, 32'h1);
    wr(OFS_EN0, 32'h0000_0203);
    wr(OFS_EN0 + 12'h4, 32'h0004_0000);
    periph_irq <= (96'h1 << 50) | 96'h207;
    @(posedge hclk);
    periph_irq <= '0;
    repeat (4) @(posedge hclk);
    chk("lines", 32'(lines), 32'h3);
    svc_en <= 1'b1;
    for (i = 0; i < 300 && cpu.srcs.size() < 3; i++) @(posedge hclk);
    repeat (6) @(posedge hclk);
    chk("services", 32'(cpu.srcs.size()), 32'h3);
    chk("src a", 32'(cpu.srcs[0]), 32'h0);
    chk("src b", 32'(cpu.srcs[1]), 32'h1);
    chk("src c", 32'(cpu.srcs[2]), 32'h9);
    chk("vec c", cpu.vecs[2], 32'hBE00_0009);
    chk("late", 32'(late_cnt), 32'h0);
    chk("spurious", 32'(cpu_vec.spurious), 32'h0);
    chk("idle lines", 32'(lines), 32'h0);
    // edge kinds on the first channel, pin 3
    wr(OFS_IMASK, 32'h7);
    for (i = 1; i < 4; i++) begin
      wr(OFS_XCFG0, 32'h34 | 32'(i));
      wr(OFS_ISTAT, 32'h7);
      gpio_port_a[3] <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("x1", 32'(x1), 32'(i[1]));
      rc("rise", OFS_ISTAT, 32'(i[1]));
      wr(OFS_ISTAT, 32'h7);
      gpio_port_a[3] <= 1'b0;
      repeat (4) @(posedge hclk);
      rc("fall", OFS_ISTAT, 32'(i[0]));
    end
    gpio_port_a[3] <= 1'b1;
    c0 = cyc;
    repeat (4) @(posedge hclk);
    bus(1'b0, OFS_XCNT0, 32'h0, v0, c1);
    chk("cnt clr", 32'(v0 <= 32'(c1 - c0)), 32'h1);
    repeat (37) @(posedge hclk);
    bus(1'b0, OFS_XCNT0, 32'h0, r, c2);
    chk("cnt run", 32'(r[15:0] - v0[15:0]), 32'(16'(c2 - c1)));
    // second channel on pin 7, then masking
    wr(OFS_XCFG0 + 12'h4, 32'h76);
    wr(OFS_ISTAT, 32'h7);
    gpio_port_a[7] <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("x2", 32'(x2), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(OFS_IMASK, 32'h0);
    repeat (3) @(posedge hclk);
    chk("x2 masked", 32'(x2 | irq), 32'h0);
    wr(OFS_IMASK, 32'h7);
    // third channel on pin 31, both routes
    for (i = 0; i < 2; i++) begin
      wr(OFS_XCFG0 + 12'h8, 32'h1F7 | 32'(i << 12));
      wr(OFS_ISTAT, 32'h7);
      gpio_port_a[31] <= ~gpio_port_a[31];
      repeat (4) @(posedge hclk);
      chk("line13", 32'(l13), 32'(i == 0));
      chk("nmi", 32'(nmi), 32'(i == 1));
    end
    wr(OFS_XCFG0 + 12'h8, 32'h1F3);
    wr(OFS_ISTAT, 32'h7);
    gpio_port_a[31] <= ~gpio_port_a[31];
    repeat (4) @(posedge hclk);
    rc("ch3 off", OFS_ISTAT, 32'h0);
    chk("nmi off", 32'(nmi | l13), 32'h0);
    end_of_test();
  end
endmodule
